//--- verilog/psl_top.sv
// Purpose: Serializer and deserializer pin control with an APB register view.
// Assumes: All pins but the APB and reserved ones are asynchronous and pass two flip-flops before use.
// Notes: Serial bits run at one bit per BIT_CYCLES clocks; slow frames drop words.
`timescale 1ns/1ns
module psl_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_word_clock,
  input wire logic tx_edge_select,
  input wire logic tx_sleep_n,
  input wire logic line_driver_enable,
  input wire logic [psl_pkg::WORD_W-1:0] parallel_word_in,
  input wire logic reserved_cfg_a,
  input wire logic reserved_cfg_b,
  input wire logic reserved_cfg_c,
  output logic serial_out_p,
  output logic serial_out_n,
  output logic serial_out_oe_n,
  input wire logic serial_in_p,
  input wire logic serial_in_n,
  input wire logic rx_edge_select,
  input wire logic rx_sleep_n,
  input wire logic rx_output_enable,
  input wire logic reserved_cfg_c_rx,
  output logic [7:0] parallel_word_out_lo,
  output logic [7:0] parallel_word_out_mid,
  output logic [7:0] parallel_word_out_hi,
  output logic parallel_word_oe_n,
  output logic recovered_clock,
  output logic recovered_clock_oe_n,
  output logic lock,
  output logic irq
);
  import psl_pkg::*;

  // Count of ones in a word, used for the balance decision.
  function automatic logic [4:0] ones_count(input logic [WORD_W-1:0] w);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < WORD_W; i++) begin
      n = n + 5'(w[i]);
    end
    return n;
  endfunction

  // Frame built LSB first: start one, balance flag, data, stop zero.
  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [WORD_W-1:0] w);
    logic inv;
    inv = (ones_count(w) > 5'(HALF_WORD));
    return {1'b0, (inv ? ~w : w), inv, 1'b1};
  endfunction

  // True for every mapped register offset.
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_INT_STATUS) ||
           (a == ADDR_INT_MASK) || (a == ADDR_RX_WORD) || (a == ADDR_TX_WORD);
  endfunction

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic s_wclk, s_tx_edge, s_tx_awake, s_lde, s_rx_edge, s_rx_awake, s_rx_oe;
  logic s_sin_p, s_sin_n;
  logic [WORD_W-1:0] s_data;

  // Two-stage synchroniser for every pin input except the APB and reserved pins.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {transmit_word_clock, tx_edge_select, tx_sleep_n, line_driver_enable,
                  rx_edge_select, rx_sleep_n, rx_output_enable, serial_in_p,
                  serial_in_n, parallel_word_in};
      sync2_q <= sync1_q;
    end
  end

  // Unpack the synchronised pins.
  assign {s_wclk, s_tx_edge, s_tx_awake, s_lde, s_rx_edge, s_rx_awake, s_rx_oe,
          s_sin_p, s_sin_n, s_data} = sync2_q;

  // ---------------- Serializer ----------------
  logic wclk_prev_q;
  logic word_edge;
  logic [3:0] tx_lock_cnt_q;
  logic tx_locked;
  logic tx_drive;
  logic word_cap;
  logic [WORD_W-1:0] hold_q;
  logic hold_valid_q;
  logic tx_start;
  logic tx_busy_q;
  logic [FRAME_BITS-1:0] tx_shift_q;
  logic [4:0] tx_bits_q;
  logic [7:0] tx_cnt_q;
  logic tx_bit;
  logic ev_overrun;

  // Word-clock edge detection on the selected edge.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wclk_prev_q <= 1'b0;
    end else begin
      wclk_prev_q <= s_wclk;
    end
  end
  assign word_edge = s_tx_edge ? (s_wclk & ~wclk_prev_q) : (~s_wclk & wclk_prev_q);

  // Transmit lock counts word-clock edges and is lost in sleep.
  always_ff @(posedge clock) begin
    if (!resetn || !s_tx_awake) begin
      tx_lock_cnt_q <= 4'h0;
    end else if (word_edge && tx_lock_cnt_q != TX_LOCK_EDGES) begin
      tx_lock_cnt_q <= tx_lock_cnt_q + 4'h1;
    end
  end
  assign tx_locked = (tx_lock_cnt_q == TX_LOCK_EDGES);
  assign tx_drive = s_tx_awake & tx_locked & s_lde;
  assign word_cap = word_edge & s_tx_awake & tx_locked;
  assign tx_start = ~tx_busy_q & hold_valid_q & tx_drive;
  assign ev_overrun = word_cap & hold_valid_q & ~tx_start;

  // Holding register for the latest captured word.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hold_q <= '0;
      hold_valid_q <= 1'b0;
    end else begin
      if (word_cap) begin
        hold_q <= s_data;
      end
      if (word_cap) begin
        hold_valid_q <= 1'b1;
      end else if (tx_start) begin
        hold_valid_q <= 1'b0;
      end
    end
  end

  // Frame shifter; aborts when the driver is released.
  always_ff @(posedge clock) begin
    if (!resetn || !tx_drive) begin
      tx_busy_q <= 1'b0;
      tx_shift_q <= '0;
      tx_bits_q <= 5'h00;
      tx_cnt_q <= 8'h00;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_shift_q <= build_frame(hold_q);
      tx_bits_q <= 5'h00;
      tx_cnt_q <= 8'h00;
    end else if (tx_busy_q) begin
      if (tx_cnt_q == BIT_CYCLES - 8'h01) begin
        tx_cnt_q <= 8'h00;
        tx_shift_q <= {1'b0, tx_shift_q[FRAME_BITS-1:1]};
        if (tx_bits_q == LAST_BIT) begin
          tx_busy_q <= 1'b0;
        end else begin
          tx_bits_q <= tx_bits_q + 5'h01;
        end
      end else begin
        tx_cnt_q <= tx_cnt_q + 8'h01;
      end
    end
  end
  assign tx_bit = tx_busy_q & tx_shift_q[0];

  // Registered serial pins; idle line sits at the stop level.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_out_p <= 1'b0;
      serial_out_n <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_p <= tx_drive & tx_bit;
      serial_out_n <= tx_drive & ~tx_bit;
      serial_out_oe_n <= ~tx_drive;
    end
  end

  // ---------------- Deserializer ----------------
  psl_rx_state_t rx_state_q;
  logic [7:0] rx_cnt_q;
  logic [4:0] rx_bits_q;
  logic [SR_W-1:0] rx_sr_q;
  logic rx_prev_q;
  logic line_bad;
  logic rx_kill;
  logic resync;
  logic bit_tick;
  logic frame_end;
  logic frame_ok;
  logic frame_bad;
  logic [1:0] good_q;
  logic rx_locked;
  logic lock_prev_q;
  logic rx_drive;
  logic [WORD_W-1:0] rx_decoded;
  logic [WORD_W-1:0] out_word_q;
  logic [7:0] rclk_cnt_q;
  logic rclk_q;
  logic oe_n_q;

  assign line_bad = ~(s_sin_p ^ s_sin_n);
  assign rx_kill = ~s_rx_awake | line_bad | resync;
  assign bit_tick = (rx_state_q == RX_BITS) && (rx_cnt_q == BIT_CYCLES - 8'h01);
  assign frame_end = bit_tick && (rx_bits_q == LAST_BIT);
  assign frame_ok = frame_end & ~s_sin_p & ~rx_kill;
  assign frame_bad = frame_end & s_sin_p & ~rx_kill;
  assign rx_decoded = rx_sr_q[0] ? ~rx_sr_q[SR_W-1:1] : rx_sr_q[SR_W-1:1];

  // Line level history for start-edge detection.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= s_sin_p;
    end
  end

  // Frame receiver: hunt a rising start edge, centre it, sample bits.
  always_ff @(posedge clock) begin
    if (!resetn || rx_kill) begin
      rx_state_q <= RX_HUNT;
      rx_cnt_q <= 8'h00;
      rx_bits_q <= 5'h00;
      rx_sr_q <= '0;
    end else begin
      case (rx_state_q)
        RX_HUNT: begin
          rx_cnt_q <= 8'h00;
          if (s_sin_p && !rx_prev_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_q >= HALF_BIT - 8'h01) begin
            rx_cnt_q <= 8'h00;
            rx_bits_q <= 5'h01;
            rx_state_q <= s_sin_p ? RX_BITS : RX_HUNT;
          end else begin
            rx_cnt_q <= rx_cnt_q + 8'h01;
          end
        end
        RX_BITS: begin
          if (bit_tick) begin
            rx_cnt_q <= 8'h00;
            if (rx_bits_q == LAST_BIT) begin
              rx_state_q <= RX_HUNT;
            end else begin
              rx_sr_q <= {s_sin_p, rx_sr_q[SR_W-1:1]};
              rx_bits_q <= rx_bits_q + 5'h01;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 8'h01;
          end
        end
        default: begin
          rx_state_q <= RX_HUNT;
        end
      endcase
    end
  end

  // Lock needs consecutive good frames; any fault restarts the count.
  always_ff @(posedge clock) begin
    if (!resetn || rx_kill || frame_bad) begin
      good_q <= 2'h0;
    end else if (frame_ok && good_q != RX_LOCK_FRAMES) begin
      good_q <= good_q + 2'h1;
    end
  end
  assign rx_locked = (good_q == RX_LOCK_FRAMES);
  assign rx_drive = s_rx_awake & rx_locked & s_rx_oe;

  // Output word and recovered clock: launch data, then the strobe edge.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      out_word_q <= '0;
      rclk_q <= 1'b0;
      rclk_cnt_q <= RCLK_HALF;
    end else if (frame_ok && rx_locked) begin
      out_word_q <= rx_decoded;
      rclk_q <= ~s_rx_edge;
      rclk_cnt_q <= 8'h00;
    end else if (rclk_cnt_q < RCLK_HALF - 8'h01) begin
      rclk_cnt_q <= rclk_cnt_q + 8'h01;
    end else begin
      rclk_q <= s_rx_edge;
      rclk_cnt_q <= RCLK_HALF;
    end
  end

  // Output enables and lock history for events.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      oe_n_q <= 1'b1;
      lock_prev_q <= 1'b0;
    end else begin
      oe_n_q <= ~rx_drive;
      lock_prev_q <= rx_locked;
    end
  end

  // Pin outputs, data split in byte groups.
  assign parallel_word_out_lo = out_word_q[7:0];
  assign parallel_word_out_mid = out_word_q[15:8];
  assign parallel_word_out_hi = out_word_q[23:16];
  assign parallel_word_oe_n = oe_n_q;
  assign recovered_clock = rclk_q;
  assign recovered_clock_oe_n = oe_n_q;
  assign lock = lock_prev_q;

  // ---------------- Registers and interrupt ----------------
  logic wr_en;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] int_status_q;
  logic [EV_W-1:0] int_mask_q;
  logic [EV_W-1:0] w1c;

  assign wr_en = psel & penable & pwrite & is_mapped(paddr);
  assign resync = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_RESYNC];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign w1c = (wr_en && paddr == ADDR_INT_STATUS) ? pwdata[EV_W-1:0] : '0;

  // Event vector for the sticky status.
  always_comb begin
    events = '0;
    events[EV_LOCK_GAIN] = rx_locked & ~lock_prev_q;
    events[EV_LOCK_LOSS] = ~rx_locked & lock_prev_q;
    events[EV_OVERRUN] = ev_overrun;
    events[EV_FRAME_ERR] = frame_bad;
  end

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      int_status_q <= '0;
    end else begin
      int_status_q <= (int_status_q & ~w1c) | events;
    end
  end

  // Mask register and level interrupt.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      int_mask_q <= INT_MASK_RST;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_INT_MASK) begin
        int_mask_q <= pwdata[EV_W-1:0];
      end
      irq <= |(int_status_q & int_mask_q);
    end
  end

  // Read data is prepared in the setup cycle and held through access.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        ADDR_STATUS: prdata <= {28'h0, rx_drive, tx_drive, rx_locked, tx_locked};
        ADDR_INT_STATUS: prdata <= {28'h0, int_status_q};
        ADDR_INT_MASK: prdata <= {28'h0, int_mask_q};
        ADDR_RX_WORD: prdata <= {8'h00, out_word_q};
        ADDR_TX_WORD: prdata <= {8'h00, hold_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // psl_top

//--- pkg/psl_pkg.sv
// Purpose: Shared constants for the parallel serial link control block.
// Assumes: 100 MHz system clock; APB register slave with 32-bit data.
// Notes: All cycle counts derive from named times and the clock period.
package psl_pkg;
  // Word and frame layout: start, balance flag, 24 data bits, stop.
  localparam int WORD_W = 24;
  localparam int FRAME_BITS = 27;
  localparam int SR_W = 25;
  localparam int HALF_WORD = 12;
  localparam int SYNC_W = 33;
  // Timing in its own unit, then in cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 40;
  localparam int RCLK_HALF_NS = 80;
  localparam logic [7:0] BIT_CYCLES =
    8'((BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HALF_BIT = 8'(BIT_CYCLES / 2);
  localparam logic [7:0] RCLK_HALF =
    8'((RCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
  // Lock acquisition counts.
  localparam logic [3:0] TX_LOCK_EDGES = 4'h4;
  localparam logic [1:0] RX_LOCK_FRAMES = 2'h2;
  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_MASK = 12'h00c;
  localparam logic [11:0] ADDR_RX_WORD = 12'h010;
  localparam logic [11:0] ADDR_TX_WORD = 12'h014;
  // Field positions.
  localparam int CTRL_RESYNC = 0;
  localparam int EV_W = 4;
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_FRAME_ERR = 3;
  // Reset values.
  localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} psl_rx_state_t;
endpackage

//--- sim/psl_top_assertions.sv
// Purpose: Concurrent checks on the link pins of psl_top.
// Assumes: One clock domain; resetn synchronous and active low.
// Notes: Asynchronous pins get a few cycles to pass the synchronisers.
`timescale 1ns/1ns
module psl_top_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic tx_sleep_n,
  input wire logic line_driver_enable,
  input wire logic serial_out_p,
  input wire logic serial_out_n,
  input wire logic serial_out_oe_n,
  input wire logic serial_in_p,
  input wire logic serial_in_n,
  input wire logic rx_edge_select,
  input wire logic rx_sleep_n,
  input wire logic rx_output_enable,
  input wire logic [7:0] parallel_word_out_lo,
  input wire logic [7:0] parallel_word_out_mid,
  input wire logic [7:0] parallel_word_out_hi,
  input wire logic parallel_word_oe_n,
  input wire logic recovered_clock,
  input wire logic recovered_clock_oe_n,
  input wire logic lock
);
  // Every check runs on the system clock and is off during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  tx_sleep_off_a: assert property (
    !tx_sleep_n [*5] |-> serial_out_oe_n && !serial_out_p && !serial_out_n)
    else $error("Serial line driven while transmit asleep.");
  driver_off_a: assert property (!line_driver_enable [*5] |-> serial_out_oe_n)
    else $error("Serial line driven while driver disabled.");
  line_pair_a: assert property (!serial_out_oe_n |-> serial_out_n == !serial_out_p)
    else $error("Serial pair not complementary while driven.");
  rx_sleep_off_a: assert property (
    !rx_sleep_n [*6] |-> !lock && parallel_word_oe_n && recovered_clock_oe_n)
    else $error("Receive outputs active while asleep.");
  rx_disable_a: assert property (
    !rx_output_enable [*5] |-> parallel_word_oe_n && recovered_clock_oe_n)
    else $error("Receive outputs driven while disabled.");
  rx_keep_lock_a: assert property (
    (lock && rx_sleep_n && serial_in_p != serial_in_n) [*3] ##0 !rx_output_enable |=> lock)
    else $error("Lock lost by output disable.");
  unlock_release_a: assert property (
    !lock && !$past(lock) |-> parallel_word_oe_n && recovered_clock_oe_n)
    else $error("Receive outputs driven while unlocked.");
  line_lost_a: assert property ((serial_in_p == serial_in_n) [*6] |-> !lock)
    else $error("Lock kept on an undriven line.");
  strobe_edge_a: assert property (
    $changed({parallel_word_out_hi, parallel_word_out_mid, parallel_word_out_lo})
      && !parallel_word_oe_n |-> recovered_clock == !rx_edge_select
      ##8 recovered_clock == rx_edge_select)
    else $error("Recovered clock edge not placed after data launch.");
endmodule // psl_top_checker

bind psl_top psl_top_checker psl_top_checker_inst (.clock, .resetn, .tx_sleep_n,
  .line_driver_enable, .serial_out_p, .serial_out_n, .serial_out_oe_n, .serial_in_p,
  .serial_in_n, .rx_edge_select, .rx_sleep_n, .rx_output_enable, .parallel_word_out_lo,
  .parallel_word_out_mid, .parallel_word_out_hi, .parallel_word_oe_n, .recovered_clock,
  .recovered_clock_oe_n, .lock);

//--- sim/psl_far_end.sv
// Purpose: Far end of the serial line: sends frames in, decodes frames out.
// Assumes: Shares the system clock; bit time of four clocks.
// Notes: A released line shows a level that toggles on both wires at once.
`timescale 1ns/1ns
module psl_far_end (
  input wire logic clock,
  input wire logic release_line,
  input wire logic serial_out_p,
  input wire logic serial_out_oe_n,
  output logic serial_in_p,
  output logic serial_in_n
);
  logic [26:0] tx_sh, rx_sh, nxt;
  logic [6:0] tx_left, rx_cnt;
  logic tgl, prev_p;
  logic [23:0] got_q[$];
  // Start from an idle driven line.
  initial begin
    tx_left = 7'h0;
    rx_cnt = 7'h0;
    tgl = 1'b0;
    prev_p = 1'b0;
    serial_in_p = 1'b0;
    serial_in_n = 1'b1;
  end
  // Start bit, balance flag, data LSB first, stop bit.
  function automatic logic [26:0] frame_of(input logic [23:0] w);
    logic inv;
    inv = $countones(w) > 12;
    return {1'b0, (inv ? ~w : w), inv, 1'b1};
  endfunction
  // Line driver: release, frame bits of four clocks each, or idle low.
  always @(posedge clock) begin
    if (release_line) begin
      serial_in_p <= tgl;
      serial_in_n <= tgl;
      tgl <= ~tgl;
    end else if (tx_left != 7'h0) begin
      serial_in_p <= tx_sh[0];
      serial_in_n <= ~tx_sh[0];
      tx_left <= tx_left - 7'h1;
      if (tx_left[1:0] == 2'h1) tx_sh <= tx_sh >> 1;
    end else begin
      serial_in_p <= 1'b0;
      serial_in_n <= 1'b1;
    end
  end
  // Sends one word and returns when its stop bit is done.
  task automatic send_word(input logic [23:0] w);
    @(posedge clock);
    tx_sh <= frame_of(w);
    tx_left <= 7'h6c;
    @(posedge clock);
    while (tx_left != 7'h0) @(posedge clock);
  endtask
  // Decoder: hunts a rising start, samples bit centres, undoes the flag.
  assign nxt = {serial_out_p, rx_sh[26:1]};
  always @(posedge clock) begin
    prev_p <= serial_out_p;
    if (serial_out_oe_n) rx_cnt <= 7'h0;
    else if (rx_cnt == 7'h0) begin
      if (serial_out_p && !prev_p) rx_cnt <= 7'h1;
    end else begin
      rx_cnt <= (rx_cnt == 7'h6a) ? 7'h0 : rx_cnt + 7'h1;
      if (rx_cnt[1:0] == 2'h2) rx_sh <= nxt;
      if (rx_cnt == 7'h6a) got_q.push_back(nxt[1] ? ~nxt[25:2] : nxt[25:2]);
    end
  end
endmodule // psl_far_end

//--- sim/tb_psl_top.sv
// Purpose: Self-checking bench for psl_top with a far end on the serial line.
// Assumes: 100 MHz clock, word clock of 160 ns that runs only when asked.
// Notes: Random words from a fixed seed; edge cases are placed by hand.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_psl_top;
  import psl_pkg::*;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, err, run_w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic twc, tx_sel, tx_sleep_n, drv_en, rx_sel, rx_sleep_n, rx_en, release_line;
  logic [23:0] din, a_w, exp_w;
  logic serial_out_p, serial_out_n, serial_out_oe_n, serial_in_p, serial_in_n;
  logic [7:0] out_lo, out_mid, out_hi;
  logic par_oe_n, rclk, rclk_oe_n, lock, irq;
  int miscompares, n_checks, cycles;
  // System clock and a word clock unrelated in phase.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #3;
    forever #80 if (run_w) twc = ~twc;
  end
  psl_top psl_top_inst (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_word_clock(twc), .tx_edge_select(tx_sel),
    .tx_sleep_n(tx_sleep_n), .line_driver_enable(drv_en), .parallel_word_in(din),
    .reserved_cfg_a(1'b0), .reserved_cfg_b(1'b0), .reserved_cfg_c(1'b0),
    .serial_out_p(serial_out_p), .serial_out_n(serial_out_n),
    .serial_out_oe_n(serial_out_oe_n), .serial_in_p(serial_in_p), .serial_in_n(serial_in_n),
    .rx_edge_select(rx_sel), .rx_sleep_n(rx_sleep_n), .rx_output_enable(rx_en),
    .reserved_cfg_c_rx(1'b0), .parallel_word_out_lo(out_lo), .parallel_word_out_mid(out_mid),
    .parallel_word_out_hi(out_hi), .parallel_word_oe_n(par_oe_n), .recovered_clock(rclk),
    .recovered_clock_oe_n(rclk_oe_n), .lock(lock), .irq(irq));
  psl_far_end far_end_inst (.clock(clock), .release_line(release_line),
    .serial_out_p(serial_out_p), .serial_out_oe_n(serial_out_oe_n),
    .serial_in_p(serial_in_p), .serial_in_n(serial_in_n));
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Waits, then moves to the falling edge where outputs are settled.
  task automatic peek(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  // Main sequence: registers, capture edges, transmit gating, receive lock.
  initial begin
    {resetn, psel, penable, pwrite, run_w, twc, release_line} = 7'h0;
    {tx_sel, tx_sleep_n, drv_en, rx_sel, rx_sleep_n, rx_en} = 6'h3f;
    paddr = 12'h0;
    pwdata = 32'h0;
    din = 24'h0;
    void'($urandom(36856));
    idle(6);
    resetn <= 1'b1;
    peek(1);
    `CHK({lock, par_oe_n, rclk_oe_n, serial_out_oe_n, irq}, 5'b01110)
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 12'h018, 32'hffffffff);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h018, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    for (int s = 1; s >= 0; s--) begin
      a_w = 24'($urandom);
      tx_sel <= s[0];
      din <= 24'($urandom);
      run_w = 1'b1;
      idle(130);
      run_w = 1'b0;
      twc <= 1'b0;
      din <= a_w;
      idle(300);
      twc <= 1'b1;
      idle(300);
      din <= ~a_w;
      idle(20);
      twc <= 1'b0;
      idle(300);
      exp_w = s[0] ? a_w : ~a_w;
      apb(1'b0, ADDR_TX_WORD, 32'h0);
      `CHK(rd[23:0], exp_w)
      `CHK(far_end_inst.got_q[$], exp_w)
    end
    drv_en <= 1'b0;
    peek(8);
    `CHK(serial_out_oe_n, 1'b1)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    drv_en <= 1'b1;
    peek(8);
    `CHK(serial_out_oe_n, 1'b0)
    idle(1);
    tx_sleep_n <= 1'b0;
    peek(8);
    `CHK({serial_out_oe_n, serial_out_p}, 2'b10)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    tx_sleep_n <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      rx_sel <= s[0];
      idle(4);
      for (int k = 0; k < 3; k++) begin
        a_w = 24'($urandom);
        far_end_inst.send_word(a_w);
      end
      peek(12);
      `CHK({lock, par_oe_n, rclk_oe_n, irq}, 4'b1001)
      `CHK({out_hi, out_mid, out_lo}, a_w)
      apb(1'b1, ADDR_INT_STATUS, 32'h3);
      peek(3);
      `CHK(irq, 1'b0)
      idle(1);
      rx_en <= 1'b0;
      peek(8);
      `CHK({lock, par_oe_n, rclk_oe_n}, 3'b111)
      idle(1);
      rx_en <= 1'b1;
      if (s == 0) release_line <= 1'b1;
      else rx_sleep_n <= 1'b0;
      peek(10);
      `CHK({lock, par_oe_n, rclk_oe_n, irq}, 4'b0110)
      apb(1'b0, ADDR_INT_STATUS, 32'h0);
      `CHK(rd[1], 1'b1)
      release_line <= 1'b0;
      rx_sleep_n <= 1'b1;
    end
    // Forced resync drops lock; one good frame afterwards is not enough to relock.
    idle(4);
    repeat (3) far_end_inst.send_word(24'($urandom));
    peek(2);
    `CHK(lock, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'h1);
    peek(4);
    `CHK(lock, 1'b0)
    far_end_inst.send_word(24'($urandom));
    peek(12);
    `CHK({lock, par_oe_n}, 2'b01)
    wrap_up();
  end
endmodule // tb_psl_top
